// [dms_check_properties.sv]
`timescale 1ns/100ps
// ****
// Port checks
// ****
module dms_check (
  input wire logic clk, // Clock
  input wire logic arst_n, // Reset
  input wire logic [7:0] reg_addr, // Reg address
  input wire logic [7:0] reg_wdata, // Reg data in
  input wire logic reg_wr, // Reg write
  input wire logic reg_rd, // Reg read
  input wire logic [7:0] reg_rdata, // Reg data out
  input wire logic [15:0] dp_active, // Pointer
  input wire logic xm_req, // Move request
  input wire logic xm_wide, // Pointer form
  input wire logic [7:0] xm_reg_addr, // Short address
  input wire logic xm_busy, // Busy
  input wire logic xm_done, // Done
  input wire logic [15:0] code_addr, // Fetch address
  input wire logic boot_rom_hit, // Boot hit
  input wire logic [7:0] p0_out, // Port 0
  input wire logic p0_oe, // Port 0 drive
  input wire logic [7:0] p2_out, // Port 2
  input wire logic p2_oe, // Port 2 drive
  input wire logic ale, // Latch
  input wire logic wr_n, // Write strobe
  input wire logic rd_n // Read strobe
);
  logic [7:0] aux_q, aux1_q;
  logic [5:0] cnt_q;
  logic [15:0] xa;
  logic onchip, take, quiet;
  assign xa = xm_wide ? dp_active : {8'h00, xm_reg_addr};
  assign onchip = !aux_q[1] && xa[15:10] == 6'h00 && xa[9:8] <= aux_q[3:2];
  assign take = xm_req && !xm_busy;
  assign quiet = wr_n && rd_n && !ale && !p0_oe && !p2_oe;
  // Shadow registers and strobe length count
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aux_q <= 8'h00;
      aux1_q <= 8'h00;
      cnt_q <= 6'h00;
    end else begin
      if (reg_wr && reg_addr == 8'h8E) begin
        aux_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == 8'hA2) begin
        aux1_q <= reg_wdata;
      end
      cnt_q <= (wr_n && rd_n) ? 6'h00 : cnt_q + 6'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_addr;
    ale && p0_oe && p0_out == $past(xa[7:0]) && p2_oe == $past(xm_wide) && (!p2_oe || p2_out == $past(xa[15:8]));
  endsequence
  sequence s_strobe;
    !ale && wr_n && rd_n ##1 !(wr_n && rd_n);
  endsequence
  a_bus_addr: assert property (take && !onchip |=> s_addr ##1 s_strobe)
    else $error("bus address phase wrong");
  a_onchip_quiet: assert property (take && onchip |=> quiet[*2] ##1 xm_done)
    else $error("on-chip move touched pins");
  a_strobe_len: assert property ($rose(wr_n && rd_n) |-> cnt_q == (aux_q[5] ? 6'd30 : 6'd6))
    else $error("strobe length wrong");
  a_strobe_excl: assert property (wr_n || rd_n)
    else $error("both strobes low");
  a_done_pulse: assert property (xm_done |=> !xm_done && !xm_busy)
    else $error("done not a pulse");
  a_aux1_read: assert property (reg_rd && reg_addr == 8'hA2 |=> reg_rdata == ($past(aux1_q) & 8'h29))
    else $error("aux one read wrong");
  a_aux_read: assert property (reg_rd && reg_addr == 8'h8E |=> reg_rdata == ($past(aux_q) & 8'h2F))
    else $error("aux read wrong");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not idle");
  a_boot_map: assert property (boot_rom_hit == (aux1_q[5] && code_addr >= 16'hF800))
    else $error("boot hit wrong");
endmodule

// [dms_expanded_ram.v]
`timescale 1ns/100ps
// ****************************************************************
// On-chip expanded RAM, registered read
// ****************************************************************
module dms_expanded_ram (
  input wire clk, // Core clock
  input wire en, // Access enable
  input wire we, // Write enable
  input wire [9:0] addr, // Byte address
  input wire [7:0] wdata, // Write data
  output reg [7:0] rdata // Read data, one cycle later
);
  reg [7:0] mem [0:1023];

  always @(posedge clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule

// [dms_iram.v]
`timescale 1ns/100ps
// ****************************************************************
// Internal 256-byte RAM, lower and upper halves
// ****************************************************************
module dms_iram (
  input wire clk, // Core clock
  input wire en, // Access enable
  input wire we, // Write enable
  input wire [7:0] addr, // Byte address
  input wire [7:0] wdata, // Write data
  output reg [7:0] rdata // Read data, one cycle later
);
  reg [7:0] mem [0:255];

  always @(posedge clk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule

// [dms_regs.vh]
`ifndef DMS_REGS_VH
`define DMS_REGS_VH

// ****************************************************************
// Special-function register addresses
// ****************************************************************
`define DMS_SFR_PTR_LO 8'h82
`define DMS_SFR_PTR_HI 8'h83
`define DMS_SFR_AUX 8'h8E
`define DMS_SFR_AUX1 8'hA2

// ****************************************************************
// Auxiliary register one fields
// ****************************************************************
`define DMS_AUX1_SEL 0
`define DMS_AUX1_FLAG 3
`define DMS_AUX1_BOOT 5
`define DMS_AUX1_RST 8'h00

// ****************************************************************
// Auxiliary register fields
// ****************************************************************
`define DMS_AUX_ALE 0
`define DMS_AUX_EXT 1
`define DMS_AUX_SZ_LO 2
`define DMS_AUX_SZ_HI 3
`define DMS_AUX_STRETCH 5
`define DMS_AUX_RST 8'h00

// ****************************************************************
// Memory map
// ****************************************************************
`define DMS_IRAM_TOP 8'h7F
`define DMS_BOOT_BASE 16'hF800
`define DMS_EXPANDED_RAM_BYTES 1024
`define DMS_EXPANDED_RAM_UNIT 11'h100

// ****************************************************************
// Strobe timing, in clock periods and in cycles
// ****************************************************************
`define DMS_STB_SHORT_CLK 5'h06
`define DMS_STB_LONG_CLK 5'h1E
`define DMS_CLK_PER_PERIOD 5'h01
`define DMS_STB_SHORT_CYC (`DMS_STB_SHORT_CLK * `DMS_CLK_PER_PERIOD)
`define DMS_STB_LONG_CYC (`DMS_STB_LONG_CLK * `DMS_CLK_PER_PERIOD)

`endif

// [dms_top.v]
// What this block does
// - Two 16-bit pointers, one active at once
// - Selection bit zero first, one second
// - Bit two reads zero, ignores writes
// - Bit three is a free user flag
// - Boot bit maps ROM at F800h-FFFFh
// - Expanded RAM 1024 bytes at 000h-3FFh
// - Addresses 00h-7Fh reach lower RAM
// - Direct 80h-FFh reaches special registers
// - Indirect above 7Fh reaches upper RAM
// - On-chip moves leave pins untouched
// - Moves above visible size use bus
// - Above 0FFh only via 16-bit pointer
// - Size bits hide part of RAM
// - Sizes 256, 512, 768, 1024; default 256
// - Register form drives 8-bit address on port 0
// - Pointer form drives high byte on port 2
// - Write and read strobes on bus cycles
// - Stack reaches internal RAM only
// - Stretch bit makes strobes 30 periods
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "dms_regs.vh"

module dms_top (
  input wire clk, // Core clock
  input wire arst_n, // Asynchronous reset, active low
  input wire [7:0] reg_addr, // Register address
  input wire [7:0] reg_wdata, // Register write data
  input wire reg_wr, // Register write strobe
  input wire reg_rd, // Register read strobe
  output reg [7:0] reg_rdata, // Register read data
  input wire dp_load, // Load active pointer
  input wire [15:0] dp_value, // Value to load
  input wire dp_inc, // Increment active pointer
  output wire [15:0] dp_active, // Active pointer value
  input wire ia_rd, // Internal data read
  input wire ia_wr, // Internal data write
  input wire [7:0] ia_addr, // Internal data address
  input wire ia_direct, // Direct addressing mode
  input wire ia_stack, // Stack push or pop
  input wire [7:0] ia_wdata, // Internal write data
  output reg [7:0] ia_rdata, // Internal read data
  input wire xm_req, // External move request
  input wire xm_write, // Move is a write
  input wire xm_wide, // 16-bit pointer form
  input wire [7:0] xm_reg_addr, // Register-indirect address
  input wire [7:0] xm_wdata, // Move write data
  output wire xm_busy, // Move in progress
  output reg xm_done, // Move finished pulse
  output reg [7:0] xm_rdata, // Move read data
  input wire [15:0] code_addr, // Code fetch address
  output wire boot_rom_hit, // Fetch falls in boot ROM
  input wire [7:0] p0_in, // Port 0 pin level
  output reg [7:0] p0_out, // Port 0 drive value
  output reg p0_oe, // Port 0 drive enable
  output reg [7:0] p2_out, // Port 2 drive value
  output reg p2_oe, // Port 2 drive enable
  output reg ale, // Address latch enable
  output reg wr_n, // Write strobe, active low
  output reg rd_n // Read strobe, active low
);

  // ****************************************************************
  // Move sequencer states
  // ****************************************************************
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ALE = 3'd1;
  localparam [2:0] S_ADDR = 3'd2;
  localparam [2:0] S_STB = 3'd3;
  localparam [2:0] S_HOLD = 3'd4;
  localparam [2:0] S_EXPANDED_RAM = 3'd5;
  localparam [2:0] S_XRD = 3'd6;

  localparam [4:0] STB_SHORT = `DMS_STB_SHORT_CYC;
  localparam [4:0] STB_LONG = `DMS_STB_LONG_CYC;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function [10:0] visible_size;
    input [1:0] sel;
    begin
      visible_size = `DMS_EXPANDED_RAM_UNIT * ({9'd0, sel} + 11'd1);
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg [15:0] ptr0_q;
  reg [15:0] ptr1_q;
  reg sel_q;
  reg flag_q;
  reg boot_q;
  reg ale_mode_q;
  reg ext_q;
  reg [1:0] size_q;
  reg stretch_q;
  reg [2:0] state_q;
  reg [4:0] cnt_q;
  reg mv_write_q;
  reg [15:0] mv_addr_q;
  reg [7:0] mv_wdata_q;
  reg [7:0] p0_s1_q;
  reg [7:0] p0_s2_q;
  reg ia_sfr_q;

  wire [7:0] iram_rdata;
  wire [7:0] expanded_ram_rdata;

  // ****************************************************************
  // Special-register access, register port first
  // ****************************************************************
  wire ia_sfr = ia_direct & ~ia_stack & ia_addr[7];
  wire ia_ram = ~ia_sfr;
  wire sfr_wr = reg_wr | (ia_wr & ia_sfr);
  wire sfr_rd = reg_rd | (ia_rd & ia_sfr);
  wire [7:0] sfr_addr = (reg_wr | reg_rd) ? reg_addr : ia_addr;
  wire [7:0] sfr_wdata = reg_wr ? reg_wdata : ia_wdata;

  wire [7:0] aux1_val;
  wire [7:0] aux_val;
  assign aux1_val = {2'b00, boot_q, 1'b0, flag_q, 1'b0, 1'b0, sel_q};
  assign aux_val = {2'b00, stretch_q, 1'b0, size_q, ext_q, ale_mode_q};

  assign dp_active = sel_q ? ptr1_q : ptr0_q;
  assign boot_rom_hit = boot_q & (code_addr >= `DMS_BOOT_BASE);

  reg [7:0] sfr_val;
  always @* begin
    case (sfr_addr)
      `DMS_SFR_PTR_LO: sfr_val = dp_active[7:0];
      `DMS_SFR_PTR_HI: sfr_val = dp_active[15:8];
      `DMS_SFR_AUX1: sfr_val = aux1_val;
      `DMS_SFR_AUX: sfr_val = aux_val;
      default: sfr_val = 8'h00;
    endcase
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_q <= 1'b0;
      flag_q <= 1'b0;
      boot_q <= 1'b0;
      ale_mode_q <= 1'b0;
      ext_q <= 1'b0;
      size_q <= 2'b00;
      stretch_q <= 1'b0;
    end else if (sfr_wr) begin
      if (sfr_addr == `DMS_SFR_AUX1) begin
        sel_q <= sfr_wdata[`DMS_AUX1_SEL];
        flag_q <= sfr_wdata[`DMS_AUX1_FLAG];
        boot_q <= sfr_wdata[`DMS_AUX1_BOOT];
      end
      if (sfr_addr == `DMS_SFR_AUX) begin
        ale_mode_q <= sfr_wdata[`DMS_AUX_ALE];
        ext_q <= sfr_wdata[`DMS_AUX_EXT];
        size_q <= sfr_wdata[`DMS_AUX_SZ_HI:`DMS_AUX_SZ_LO];
        stretch_q <= sfr_wdata[`DMS_AUX_STRETCH];
      end
    end
  end

  // ****************************************************************
  // Data pointers; the unselected one is left alone
  // ****************************************************************
  reg [15:0] ptr_d;
  reg ptr_we;
  always @* begin
    ptr_d = dp_active;
    ptr_we = 1'b0;
    if (dp_load) begin
      ptr_d = dp_value;
      ptr_we = 1'b1;
    end else if (dp_inc) begin
      ptr_d = dp_active + 16'h0001;
      ptr_we = 1'b1;
    end else if (sfr_wr && sfr_addr == `DMS_SFR_PTR_LO) begin
      ptr_d = {dp_active[15:8], sfr_wdata};
      ptr_we = 1'b1;
    end else if (sfr_wr && sfr_addr == `DMS_SFR_PTR_HI) begin
      ptr_d = {sfr_wdata, dp_active[7:0]};
      ptr_we = 1'b1;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr0_q <= 16'h0000;
      ptr1_q <= 16'h0000;
    end else if (ptr_we) begin
      if (sel_q) begin
        ptr1_q <= ptr_d;
      end else begin
        ptr0_q <= ptr_d;
      end
    end
  end

  // ****************************************************************
  // Read data paths
  // ****************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
      ia_sfr_q <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? sfr_val : 8'h00;
      ia_sfr_q <= ia_sfr;
    end
  end

  reg [7:0] sfr_ia_q;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_ia_q <= 8'h00;
    end else if (ia_rd & ia_sfr & ~reg_rd & ~reg_wr) begin
      sfr_ia_q <= sfr_val;
    end
  end

  always @* begin
    ia_rdata = ia_sfr_q ? sfr_ia_q : iram_rdata;
  end

  dms_iram u_iram (
    .clk(clk),
    .en((ia_rd | ia_wr) & ia_ram),
    .we(ia_wr),
    .addr(ia_addr),
    .wdata(ia_wdata),
    .rdata(iram_rdata)
  );

  // ****************************************************************
  // Move steering
  // ****************************************************************
  wire [15:0] req_addr = xm_wide ? dp_active : {8'h00, xm_reg_addr};
  wire req_onchip = ~ext_q & (req_addr < {5'd0, visible_size(size_q)});
  wire [4:0] stb_len = stretch_q ? STB_LONG : STB_SHORT;

  assign xm_busy = (state_q != S_IDLE);

  dms_expanded_ram u_expanded_ram (
    .clk(clk),
    .en(state_q == S_EXPANDED_RAM),
    .we(mv_write_q),
    .addr(mv_addr_q[9:0]),
    .wdata(mv_wdata_q),
    .rdata(expanded_ram_rdata)
  );

  // ****************************************************************
  // Port 0 input synchroniser
  // ****************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      p0_s1_q <= 8'h00;
      p0_s2_q <= 8'h00;
    end else begin
      p0_s1_q <= p0_in;
      p0_s2_q <= p0_s1_q;
    end
  end

  // ****************************************************************
  // Move sequencer and pins
  // ****************************************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_IDLE;
      cnt_q <= 5'd0;
      mv_write_q <= 1'b0;
      mv_addr_q <= 16'h0000;
      mv_wdata_q <= 8'h00;
      xm_done <= 1'b0;
      xm_rdata <= 8'h00;
      p0_out <= 8'h00;
      p0_oe <= 1'b0;
      p2_out <= 8'h00;
      p2_oe <= 1'b0;
      ale <= 1'b0;
      wr_n <= 1'b1;
      rd_n <= 1'b1;
    end else begin
      xm_done <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (xm_req) begin
            mv_write_q <= xm_write;
            mv_addr_q <= req_addr;
            mv_wdata_q <= xm_wdata;
            if (req_onchip) begin
              state_q <= S_EXPANDED_RAM;
            end else begin
              state_q <= S_ALE;
              ale <= 1'b1;
              p0_out <= req_addr[7:0];
              p0_oe <= 1'b1;
              p2_out <= req_addr[15:8];
              p2_oe <= xm_wide;
            end
          end
        end
        S_ALE: begin
          ale <= 1'b0;
          state_q <= S_ADDR;
        end
        S_ADDR: begin
          cnt_q <= stb_len - 5'd1;
          p0_out <= mv_wdata_q;
          p0_oe <= mv_write_q;
          wr_n <= ~mv_write_q;
          rd_n <= mv_write_q;
          state_q <= S_STB;
        end
        S_STB: begin
          if (cnt_q == 5'd0) begin
            wr_n <= 1'b1;
            rd_n <= 1'b1;
            if (!mv_write_q) begin
              xm_rdata <= p0_s2_q;
            end
            state_q <= S_HOLD;
          end else begin
            cnt_q <= cnt_q - 5'd1;
          end
        end
        S_HOLD: begin
          p0_oe <= 1'b0;
          p2_oe <= 1'b0;
          xm_done <= 1'b1;
          state_q <= S_IDLE;
        end
        S_EXPANDED_RAM: begin
          state_q <= S_XRD;
        end
        S_XRD: begin
          if (!mv_write_q) begin
            xm_rdata <= expanded_ram_rdata;
          end
          xm_done <= 1'b1;
          state_q <= S_IDLE;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// [dms_top_bench.sv]
`timescale 1ns/100ps
module dms_top_bench;
  logic clk, arst_n, reg_wr, reg_rd, dp_load, dp_inc, ia_rd, ia_wr, ia_direct, ia_stack, slow, saw_ale;
  logic xm_req, xm_write, xm_wide, xm_busy, xm_done, boot_rom_hit, p0_oe, p2_oe, ale, wr_n, rd_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ia_addr, ia_wdata, ia_rdata, xm_reg_addr, xm_wdata, xm_rdata;
  logic [7:0] p0_in, p0_out, p2_out, p0_drv;
  logic [15:0] dp_value, dp_active, code_addr;
  logic [31:0] r;
  int fails, checks, cyc;
  // Row: bus expected, aux value, pointer form, address
  logic [31:0] rows [0:10] = '{32'h0000_00A0, 32'h1001_0100, 32'h0041_01FF, 32'h1041_0200, 32'h0081_02FF,
    32'h1081_0300, 32'h00C1_03FF, 32'h10C1_0400, 32'h1020_0010, 32'h1221_8001, 32'h0000_00FF};
  assign p0_in = p0_oe ? p0_out : p0_drv;
  dms_top dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dp_load(dp_load), .dp_value(dp_value), .dp_inc(dp_inc),
    .dp_active(dp_active), .ia_rd(ia_rd), .ia_wr(ia_wr), .ia_addr(ia_addr), .ia_direct(ia_direct),
    .ia_stack(ia_stack), .ia_wdata(ia_wdata), .ia_rdata(ia_rdata), .xm_req(xm_req), .xm_write(xm_write),
    .xm_wide(xm_wide), .xm_reg_addr(xm_reg_addr), .xm_wdata(xm_wdata), .xm_busy(xm_busy), .xm_done(xm_done),
    .xm_rdata(xm_rdata), .code_addr(code_addr), .boot_rom_hit(boot_rom_hit), .p0_in(p0_in), .p0_out(p0_out),
    .p0_oe(p0_oe), .p2_out(p2_out), .p2_oe(p2_oe), .ale(ale), .wr_n(wr_n), .rd_n(rd_n));
  dms_xmem mem_u (.clk(clk), .slow(slow), .p0_out(p0_out), .p2_out(p2_out), .p2_oe(p2_oe), .ale(ale),
    .wr_n(wr_n), .rd_n(rd_n), .p0_drv(p0_drv));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (xm_req && !xm_busy) begin
      saw_ale <= 1'b0;
    end else if (ale) begin
      saw_ale <= 1'b1;
    end
    if (cyc == 6000) begin
      fails++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] e, input string nm);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk(nm, {8'h00, reg_rdata}, {8'h00, e});
  endtask
  task automatic dl(input logic [15:0] v);
    dp_load <= 1'b1;
    dp_value <= v;
    @(posedge clk);
    dp_load <= 1'b0;
  endtask
  task automatic ia_op(input logic w, input logic dir, input logic stk, input logic [7:0] a, input logic [7:0] d);
    ia_rd <= !w;
    ia_wr <= w;
    ia_direct <= dir;
    ia_stack <= stk;
    ia_addr <= a;
    ia_wdata <= d;
    @(posedge clk);
    ia_rd <= 1'b0;
    ia_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic move(input logic w, input logic wd, input logic [7:0] ra, input logic [7:0] d);
    int n;
    n = 0;
    xm_req <= 1'b1;
    xm_write <= w;
    xm_wide <= wd;
    xm_reg_addr <= ra;
    xm_wdata <= d;
    @(posedge clk);
    xm_req <= 1'b0;
    while (xm_done !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("done", {15'h0000, xm_done}, 16'h0001);
  endtask
  initial begin
    {arst_n, reg_wr, reg_rd, dp_load, dp_inc, ia_rd, ia_wr, ia_direct, ia_stack, xm_req, xm_write, xm_wide} = '0;
    {reg_addr, reg_wdata, ia_addr, ia_wdata, xm_reg_addr, xm_wdata, dp_value, code_addr} = '0;
    {slow, fails, checks, cyc} = '0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 11; i++) begin
      r = rows[i];
      slow <= r[25];
      wreg(8'h8E, r[27:20]);
      if (r[16]) begin
        dl(r[15:0]);
      end
      move(1'b1, r[16], r[7:0], 8'h30 + i[7:0]);
      chk("bus_wr", {15'h0000, saw_ale}, {15'h0000, r[28]});
      move(1'b0, r[16], r[7:0], 8'h00);
      chk("bus_rd", {15'h0000, saw_ale}, {15'h0000, r[28]});
      chk("xdata", {8'h00, xm_rdata}, {8'h00, 8'h30 + i[7:0]});
    end
    $display("test rows done");
    wreg(8'hA2, 8'h00);
    dl(16'h1234);
    wreg(8'hA2, 8'h01);
    dl(16'hABCD);
    dp_inc <= 1'b1;
    @(posedge clk);
    dp_inc <= 1'b0;
    @(posedge clk);
    chk("dp_b", dp_active, 16'hABCE);
    rreg(8'h83, 8'hAB, "ptr_hi");
    wreg(8'hA2, 8'h00);
    @(posedge clk);
    chk("dp_a", dp_active, 16'h1234);
    $display("test pointers done");
    wreg(8'hA2, 8'h2D);
    rreg(8'hA2, 8'h29, "aux1");
    code_addr <= 16'hF800;
    @(posedge clk);
    chk("boot_in", {15'h0000, boot_rom_hit}, 16'h0001);
    code_addr <= 16'hF7FF;
    @(posedge clk);
    chk("boot_out", {15'h0000, boot_rom_hit}, 16'h0000);
    rreg(8'h90, 8'h00, "unmapped");
    ia_op(1'b1, 1'b1, 1'b0, 8'h82, 8'h5A);
    rreg(8'h82, 8'h5A, "sfr_direct");
    ia_op(1'b1, 1'b0, 1'b0, 8'h82, 8'h77);
    ia_op(1'b0, 1'b0, 1'b0, 8'h82, 8'h00);
    chk("upper", {8'h00, ia_rdata}, 16'h0077);
    rreg(8'h82, 8'h5A, "sfr_kept");
    ia_op(1'b1, 1'b1, 1'b1, 8'hC0, 8'h99);
    ia_op(1'b0, 1'b0, 1'b0, 8'hC0, 8'h00);
    chk("stack", {8'h00, ia_rdata}, 16'h0099);
    ia_op(1'b1, 1'b0, 1'b0, 8'h30, 8'h11);
    ia_op(1'b0, 1'b1, 1'b0, 8'h30, 8'h00);
    chk("lower", {8'h00, ia_rdata}, 16'h0011);
    $display("test internal done");
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    chk("dp_rst", dp_active, 16'h0000);
    chk("stb_rst", {14'h0000, wr_n, rd_n}, 16'h0003);
    rreg(8'h8E, 8'h00, "aux_rst");
    rreg(8'hA2, 8'h00, "aux1_rst");
    $display("test reset done");
    finish_test();
  end
endmodule
bind dms_top dms_check chk_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dp_active(dp_active), .xm_req(xm_req),
  .xm_wide(xm_wide), .xm_reg_addr(xm_reg_addr), .xm_busy(xm_busy), .xm_done(xm_done), .code_addr(code_addr),
  .boot_rom_hit(boot_rom_hit), .p0_out(p0_out), .p0_oe(p0_oe), .p2_out(p2_out), .p2_oe(p2_oe), .ale(ale),
  .wr_n(wr_n), .rd_n(rd_n));

// [dms_xmem.sv]
`timescale 1ns/100ps
// ****
// Slow external memory
// ****
module dms_xmem (
  input wire logic clk, // Clock
  input wire logic slow, // Late read data
  input wire logic [7:0] p0_out, // Port 0
  input wire logic [7:0] p2_out, // Port 2
  input wire logic p2_oe, // Port 2 drive
  input wire logic ale, // Latch
  input wire logic wr_n, // Write strobe
  input wire logic rd_n, // Read strobe
  output logic [7:0] p0_drv // Port 0 when released
);
  logic [7:0] mem [0:65535];
  logic [15:0] addr_q;
  logic [4:0] lag_q;
  logic [7:0] last_q = 8'h00;
  logic give;
  assign give = !rd_n && lag_q >= (slow ? 5'd10 : 5'd0);
  // Released bus toggles every cycle
  assign p0_drv = give ? mem[addr_q] : ~last_q;
  always @(posedge clk) begin
    last_q <= p0_drv;
    if (ale) begin
      addr_q <= {p2_oe ? p2_out : 8'h00, p0_out};
    end
    if (!wr_n) begin
      mem[addr_q] <= p0_out;
    end
    lag_q <= rd_n ? 5'd0 : lag_q + {4'h0, lag_q != 5'd31};
  end
endmodule
